/* File: ndca_consts.svh */
`ifndef NDCA_CONSTS_SVH
`define NDCA_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define NDCA_IDX_DATA_LOW 9'h10C
`define NDCA_IDX_ADDR_LOW 9'h10D
`define NDCA_IDX_ADDR_HIGH 9'h10F
`define NDCA_IDX_CONTROL 9'h11B
`define NDCA_IDX_DATA_HIGH 9'h18E
`define NDCA_IDX_UNLOCK 9'h19D
`define NDCA_IDX_FLAGS 9'h00C

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define NDCA_CTL_SPACE 7
`define NDCA_CTL_WAIT_HI 5
`define NDCA_CTL_WAIT_LO 4
`define NDCA_CTL_FAULT 3
`define NDCA_CTL_ALLOW 2
`define NDCA_CTL_WR 1
`define NDCA_CTL_RD 0
`define NDCA_FLAG_DONE 0
`define NDCA_ADDR_HIGH_MASK 8'h1F
`define NDCA_UNLOCK_KEY1 8'h55
`define NDCA_UNLOCK_KEY2 8'hAA
`define NDCA_ERASED 8'hFF
`define NDCA_RESET_BYTE 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define NDCA_WAIT_BASE_US 1250
`define NDCA_CLK_PERIOD_NS 4
`define NDCA_WAIT_BASE_CYCLES (`NDCA_WAIT_BASE_US * 1000 / `NDCA_CLK_PERIOD_NS)

`endif

/* File: ndca_pkg.sv */
package ndca_pkg;

    typedef struct packed {
        logic space_sel;
        logic [1:0] wait_sel;
        logic fault;
        logic allow;
        logic wr;
        logic rd;
    } ndca_ctrl_t;

    typedef struct packed {
        logic [7:0] data;
        logic [6:0] addr;
    } ndca_store_op_t;

    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_KEY1,
        LOCK_ARMED
    } ndca_lock_t;

endpackage : ndca_pkg

/* File: ndca_top.sv */
// Function
// - 8K-word code space, read only here
// - 128-byte data store, readable and writable
// - Store access uses low data, low address
// - Code read: 16-bit data, 13-bit address
// - Store write erases then programs the byte
// - Wait field selects 1.25/2.5/5/10 ms
// - Protection blocks programmer, not the CPU
// - Space select bit 7, reset 0 store
// - Triggers set by software, cleared by hardware
// - Write allow gates writes, resets to 0
// - Fault flag on aborted or unverified write
// - Write done flag set, software clears
// - Unlock port stores nothing, reads zero
// - Data high upper, data low lower byte
// - Address high holds five bits, rest zero
// - Write starts only after 55h, AAh, trigger
// - Allow clearing mid-write harmless; done sets flag
// - Read result latched on the second cycle
// - CPU halted while a store write runs
`include "ndca_consts.svh"

module ndca_top
    import ndca_pkg::*;
#(
    parameter int STORE_DEPTH = 128,
    parameter int CODE_AW = 13,
    parameter int WAIT_BASE_CYCLES = `NDCA_WAIT_BASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    output logic [CODE_AW-1:0] code_addr_q,
    input wire logic [15:0] code_data,
    input wire logic write_abort,
    input wire logic code_protect,
    input wire logic prog_req,
    output logic prog_grant_q,
    output logic cpu_halt_q,
    output logic write_done_q
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] wait_len(input logic [1:0] sel);
        wait_len = 32'(WAIT_BASE_CYCLES) << sel;
    endfunction : wait_len

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    ndca_ctrl_t ctrl_q;
    ndca_lock_t lock_q;
    ndca_store_op_t op_q;
    logic [7:0] data_low_q;
    logic [7:0] data_high_q;
    logic [7:0] addr_low_q;
    logic [4:0] addr_high_q;
    logic [7:0] store_q [STORE_DEPTH];
    logic busy_q;
    logic fetch_q;
    logic [31:0] wait_cnt_q;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire logic [8:0] idx = paddr[10:2];
    wire logic aligned = (paddr[1:0] == 2'b00) && !paddr[11];
    wire logic hit_dlow = aligned && (idx == `NDCA_IDX_DATA_LOW);
    wire logic hit_alow = aligned && (idx == `NDCA_IDX_ADDR_LOW);
    wire logic hit_ahigh = aligned && (idx == `NDCA_IDX_ADDR_HIGH);
    wire logic hit_ctrl = aligned && (idx == `NDCA_IDX_CONTROL);
    wire logic hit_dhigh = aligned && (idx == `NDCA_IDX_DATA_HIGH);
    wire logic hit_unlock = aligned && (idx == `NDCA_IDX_UNLOCK);
    wire logic hit_flags = aligned && (idx == `NDCA_IDX_FLAGS);
    wire logic hit = hit_dlow | hit_alow | hit_ahigh | hit_ctrl | hit_dhigh | hit_unlock | hit_flags;

    wire logic apb_phase = psel && penable && !pready_q;
    wire logic wr_done = psel && penable && pready_q && pwrite && !pslverr_q;
    wire logic [7:0] wdata8 = pwdata[7:0];

    wire logic we_dlow = wr_done && hit_dlow;
    wire logic we_alow = wr_done && hit_alow;
    wire logic we_ahigh = wr_done && hit_ahigh;
    wire logic we_ctrl = wr_done && hit_ctrl;
    wire logic we_dhigh = wr_done && hit_dhigh;
    wire logic we_unlock = wr_done && hit_unlock;
    wire logic we_flags = wr_done && hit_flags;

    // Unlock port bytes are never stored; they only step or reset the unlock sequence.
    wire logic [7:0] ctrl_rd = {ctrl_q.space_sel, 1'b0, ctrl_q.wait_sel, ctrl_q.fault,
                                ctrl_q.allow, ctrl_q.wr, ctrl_q.rd};
    wire logic [7:0] rd_mux = hit_dlow ? data_low_q :
                              hit_alow ? addr_low_q :
                              hit_ahigh ? {3'b000, addr_high_q} :
                              hit_ctrl ? ctrl_rd :
                              hit_dhigh ? data_high_q :
                              hit_flags ? {7'b0000000, write_done_q} :
                              8'h00;

    // ------------------------------------------------------------------------
    // Operation control
    // ------------------------------------------------------------------------
    // The write must be the very next error-free bus write after the two keys; any other
    // error-free write in between drops the armed state, which guards against runaway code.
    wire logic start_write = we_ctrl && wdata8[`NDCA_CTL_WR] && (lock_q == LOCK_ARMED)
                             && ctrl_q.allow && !wdata8[`NDCA_CTL_SPACE] && !busy_q;
    wire logic start_read = we_ctrl && wdata8[`NDCA_CTL_RD] && !busy_q && !ctrl_q.rd && !fetch_q;
    wire logic write_end = busy_q && (wait_cnt_q == 32'd0);
    wire logic aborted = busy_q && write_abort;
    wire logic [6:0] store_idx = addr_low_q[6:0];
    wire logic read_code = ctrl_q.space_sel;

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            pready_q <= apb_phase;
            pslverr_q <= apb_phase && !hit;
            prdata_q <= (apb_phase && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= LOCK_IDLE;
        end else if (ce && wr_done) begin
            if (we_unlock && wdata8 == `NDCA_UNLOCK_KEY1) begin
                lock_q <= LOCK_KEY1;
            end else if (we_unlock && wdata8 == `NDCA_UNLOCK_KEY2 && lock_q == LOCK_KEY1) begin
                lock_q <= LOCK_ARMED;
            end else begin
                lock_q <= LOCK_IDLE;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else if (ce) begin
            if (we_ctrl) begin
                ctrl_q.space_sel <= wdata8[`NDCA_CTL_SPACE];
                ctrl_q.wait_sel <= wdata8[`NDCA_CTL_WAIT_HI:`NDCA_CTL_WAIT_LO];
                ctrl_q.allow <= wdata8[`NDCA_CTL_ALLOW];
                ctrl_q.fault <= wdata8[`NDCA_CTL_FAULT];
            end
            // Hardware updates follow the software write so they win.
            if (start_read) begin
                ctrl_q.rd <= 1'b1;
            end else if (fetch_q) begin
                ctrl_q.rd <= 1'b0;
            end
            if (start_write) begin
                ctrl_q.wr <= 1'b1;
                ctrl_q.fault <= 1'b1;
            end else if (aborted) begin
                ctrl_q.wr <= 1'b0;
                ctrl_q.fault <= 1'b1;
            end else if (write_end) begin
                ctrl_q.wr <= 1'b0;
                ctrl_q.fault <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_low_q <= `NDCA_RESET_BYTE;
            addr_high_q <= 5'b00000;
            data_low_q <= `NDCA_RESET_BYTE;
            data_high_q <= `NDCA_RESET_BYTE;
            code_addr_q <= '0;
            fetch_q <= 1'b0;
        end else if (ce) begin
            if (we_alow) begin
                addr_low_q <= wdata8;
            end
            if (we_ahigh) begin
                addr_high_q <= 5'(wdata8 & `NDCA_ADDR_HIGH_MASK);
            end
            if (we_dhigh) begin
                data_high_q <= wdata8;
            end
            if (we_dlow) begin
                data_low_q <= wdata8;
            end
            fetch_q <= start_read;
            if (start_read) begin
                code_addr_q <= CODE_AW'({addr_high_q, addr_low_q});
            end
            // The second cycle latches the result; it overrides a bus write.
            if (fetch_q) begin
                if (read_code) begin
                    data_high_q <= code_data[15:8];
                    data_low_q <= code_data[7:0];
                end else begin
                    data_low_q <= store_q[store_idx];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Store write timing
    // ------------------------------------------------------------------------
    // The byte and address are captured at start, so later register writes
    // (including clearing write allow) cannot disturb the running write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            wait_cnt_q <= 32'd0;
            op_q <= '0;
            cpu_halt_q <= 1'b0;
            write_done_q <= 1'b0;
        end else if (ce) begin
            if (we_flags && !wdata8[`NDCA_FLAG_DONE]) begin
                write_done_q <= 1'b0;
            end
            if (start_write) begin
                busy_q <= 1'b1;
                cpu_halt_q <= 1'b1;
                wait_cnt_q <= wait_len(ctrl_q.wait_sel) - 32'd1;
                op_q <= '{data: data_low_q, addr: store_idx};
            end else if (aborted) begin
                busy_q <= 1'b0;
                cpu_halt_q <= 1'b0;
            end else if (write_end) begin
                busy_q <= 1'b0;
                cpu_halt_q <= 1'b0;
                write_done_q <= 1'b1;
            end else if (busy_q) begin
                wait_cnt_q <= wait_cnt_q - 32'd1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Data store array
    // ------------------------------------------------------------------------
    // Contents are nonvolatile in spirit, so reset leaves them alone.
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (start_write) begin
                store_q[store_idx] <= `NDCA_ERASED;
            end else if (write_end && !write_abort) begin
                store_q[op_q.addr] <= op_q.data;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Programmer access
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_grant_q <= 1'b0;
        end else if (ce) begin
            prog_grant_q <= prog_req && !code_protect;
        end
    end

endmodule : ndca_top

/* File: ndca_top_props.sv */
module ndca_top_props
    import ndca_pkg::*;
#(
    parameter int WAIT_BASE_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata_q,
    input wire logic pready_q,
    input wire logic pslverr_q,
    input wire logic write_abort,
    input wire logic code_protect,
    input wire logic prog_req,
    input wire logic prog_grant_q,
    input wire logic cpu_halt_q,
    input wire logic write_done_q
);
    // ------------------------------------------------------------------------
    // Halt length counter
    // ------------------------------------------------------------------------
    // A counter keeps the longest wait out of a repetition the tools must unroll.
    localparam int HALT_MAX = WAIT_BASE_CYCLES * 8 + 1;
    logic [31:0] halt_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) halt_cnt_q <= '0;
        else if (!cpu_halt_q) halt_cnt_q <= '0;
        else if (ce) halt_cnt_q <= halt_cnt_q + 32'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        psel && penable && !pready_q && ce;
    endsequence
    sequence s_done_wr;
        $past(psel && penable && pready_q && pwrite);
    endsequence
    a_ready_answer: assert property (s_take |=> pready_q) else $error("no answer after access");
    a_ready_pulse: assert property (pready_q && ce |=> !pready_q) else $error("ready held");
    a_rdata_idle: assert property (!pready_q |-> prdata_q == 32'h0) else $error("read data outside answer");
    a_rdata_upper: assert property (prdata_q[31:8] == 24'h0) else $error("read data upper bits set");
    a_err_ready: assert property (pslverr_q |-> pready_q && psel && penable) else $error("stray error");
    a_grant_rule: assert property (ce |=> prog_grant_q == $past(prog_req && !code_protect))
        else $error("programmer grant wrong");
    a_halt_start: assert property ($rose(cpu_halt_q) |-> s_done_wr) else $error("halt without bus write");
    a_halt_bound: assert property (halt_cnt_q <= HALT_MAX) else $error("halt too long");
    a_done_clean: assert property ($fell(cpu_halt_q) && !$past(write_abort) |-> write_done_q)
        else $error("done flag missing");
    a_done_sticky: assert property (write_done_q && !(psel && penable && pready_q && pwrite
        && paddr == 12'h030) |=> write_done_q) else $error("done flag lost");
endmodule : ndca_top_props

bind ndca_top ndca_top_props #(.WAIT_BASE_CYCLES(WAIT_BASE_CYCLES)) u_props (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .prdata_q, .pready_q, .pslverr_q, .write_abort, .code_protect, .prog_req,
    .prog_grant_q, .cpu_halt_q, .write_done_q);

/* File: nvm_data_and_code_access_bench.sv */
`include "ndca_consts.svh"

module nvm_data_and_code_access_bench
    import ndca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [8:0] DL = `NDCA_IDX_DATA_LOW;
    localparam logic [8:0] AL = `NDCA_IDX_ADDR_LOW;
    localparam logic [8:0] AH = `NDCA_IDX_ADDR_HIGH;
    localparam logic [8:0] CTL = `NDCA_IDX_CONTROL;
    localparam logic [8:0] DH = `NDCA_IDX_DATA_HIGH;
    localparam logic [8:0] UNL = `NDCA_IDX_UNLOCK;
    localparam logic [8:0] FLG = `NDCA_IDX_FLAGS;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata_q, rd;
    logic pready_q, pslverr_q, prog_grant_q, cpu_halt_q, write_done_q, er;
    logic [12:0] code_addr_q;
    logic [15:0] code_data;
    logic write_abort = 0, code_protect = 0, prog_req = 0;
    int error_cnt = 0, total_checks = 0, halt_cnt = 0, w;
    // Code memory: halves differ at address 1FFFh, so a swapped or shifted word is caught.
    assign code_data = {code_addr_q[7:0], 3'b101, code_addr_q[12:8]};
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk) if (cpu_halt_q === 1'b1) halt_cnt++;
    ndca_top #(.WAIT_BASE_CYCLES(4)) DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_q, .pready_q, .pslverr_q, .code_addr_q, .code_data, .write_abort, .code_protect, .prog_req,
        .prog_grant_q, .cpu_halt_q, .write_done_q);
    // ------------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------------
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task apb(input logic wr_en, input logic [8:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_q !== 1'b1 && n < 20);
        if (pready_q !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
        rd = prdata_q;
        er = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [8:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task rdchk(input logic [8:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask : rdchk
    task unlock;
        wr(UNL, 8'h55);
        wr(UNL, 8'hAA);
    endtask : unlock
    task start_read(input logic [7:0] ctl);
        wr(CTL, ctl);
        repeat (2) @(posedge pclk);
    endtask : start_read
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(AL, 32'h0);
        rdchk(AH, 32'h0);
        rdchk(CTL, 32'h0);
        rdchk(FLG, 32'h0);
        wr(AH, 8'hFF);
        rdchk(AH, 32'h1F);
        wr(UNL, 8'h55);
        rdchk(UNL, 32'h0);
        apb(1'b0, 9'h1FF, 8'h00);
        check(er, 32'h1);
        code_protect <= 1'b1;
        prog_req <= 1'b1;
        wr(AL, 8'hFF);
        start_read(8'h81);
        check(code_addr_q, 32'h1FFF);
        check(prog_grant_q, 32'h0);
        rdchk(DH, 32'hFF);
        rdchk(DL, 32'hBF);
        rdchk(CTL, 32'h80);
        code_protect <= 1'b0;
        repeat (2) @(posedge pclk);
        check(prog_grant_q, 32'h1);
        wr(CTL, 8'h84);
        unlock();
        wr(CTL, 8'h86);
        rdchk(CTL, 32'h84);
        wr(CTL, 8'h04);
        wr(CTL, 8'h06);
        rdchk(CTL, 32'h04);
        wr(UNL, 8'hAA);
        wr(UNL, 8'h55);
        wr(CTL, 8'h06);
        rdchk(CTL, 32'h04);
        wr(CTL, 8'h00);
        unlock();
        wr(CTL, 8'h02);
        rdchk(CTL, 32'h00);
        for (w = 0; w < 4; w++) begin
            wr(AL, 8'(8'h80 + w));
            wr(DL, 8'(8'hC0 + w));
            wr(CTL, 8'((w << 4) | 4));
            unlock();
            wr(CTL, 8'((w << 4) | 6));
            halt_cnt = 0;
            // Fault is software-writable, so keep it set while dropping allow.
            if (w == 3) wr(CTL, 8'h38);
            rdchk(CTL, (w == 3) ? 32'h3A : (w << 4) | 32'hE);
            apb(1'b0, FLG, 8'h00);
            for (int n = 0; n < 200 && write_done_q !== 1'b1; n++) @(posedge pclk);
            check(write_done_q, 32'h1);
            check(halt_cnt >= (4 << w) && halt_cnt <= (4 << w) + 1, 32'h1);
            rdchk(CTL, (w == 3) ? 32'h30 : (w << 4) | 4);
            rdchk(FLG, 32'h1);
            wr(FLG, 8'h00);
            rdchk(FLG, 32'h0);
            wr(AL, 8'(w));
            start_read(8'h01);
            rdchk(DL, 8'hC0 + w);
        end
        wr(AL, 8'h02);
        wr(CTL, 8'h34);
        unlock();
        wr(CTL, 8'h36);
        repeat (3) @(posedge pclk);
        write_abort <= 1'b1;
        @(posedge pclk);
        write_abort <= 1'b0;
        rdchk(CTL, 32'h3C);
        check(write_done_q, 32'h0);
        start_read(8'h01);
        rdchk(DL, 32'hFF);
        print_verdict();
    end
endmodule : nvm_data_and_code_access_bench
